// ===== verilog/rti_map.vh
// Purpose: constants for the serial-port watchdog and supply-sequencing block
// Assumes: 100 MHz system clock
// Notes: timing figures kept in their own units, cycle counts derived from them
`ifndef RTI_MAP_VH
`define RTI_MAP_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define RTI_CLK_MHZ 100
`define RTI_DET_INTERVAL_US 31250
`define RTI_ACC_WAIT_MS 40
`define RTI_TOUT_TICKS 2'h2
`define RTI_POR_CYCLES 5'h10

// ****************************************************************
// serial port layout
// ****************************************************************
`define RTI_SLAVE_ADDR 7'h32
`define RTI_BYTE_BITS 4'h8

// ****************************************************************
// port states
// ****************************************************************
`define RTI_ST_IDLE 3'h0
`define RTI_ST_ADDR 3'h1
`define RTI_ST_AACK 3'h2
`define RTI_ST_WDAT 3'h3
`define RTI_ST_WACK 3'h4
`define RTI_ST_RDAT 3'h5
`define RTI_ST_RACK 3'h6

`endif

// ===== verilog/rti_sync.v
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps

module rti_sync #(
    parameter W = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

// ****************************************************************
// synchroniser stages
// ****************************************************************
reg [W-1:0] meta_r; // first stage, read by the second stage only

// two flops per bit, frozen while ce is low
always @(posedge clk)
begin
    if (sys_rst)
    begin
        meta_r <= {W{1'b0}};
        q <= {W{1'b0}};
    end
    else if (ce)
    begin
        meta_r <= d;
        q <= meta_r;
    end
end

endmodule

// ===== verilog/rti_top.v
// Purpose: two-wire slave port with bus watchdog, plus power-on and supply sequencing
// Assumes: tick_1hz is a one-cycle pulse from on-chip logic on clk
// Notes: register map lives outside; bytes leave on wr_data/wr_stb and enter on rd_data
//
// Functional notes
// [RULE1] two 1 Hz ticks after address: reset, release
// [RULE2] host finishes address to stop within one second
// [RULE3] sample on rise, commit byte with ack
// [RULE4] broken-off partial byte is discarded
// [RULE5] host waits 40 ms after first power
// [RULE6] host waits 40 ms after supply restore
// [RULE7] backup mode checks main supply every 31.25 ms
// [RULE8] power-on reset starts from either supply
// [RULE9] timeout restarts on address, clears on stop
`timescale 1ns/1ps
`include "rti_map.vh"

module rti_top #(
    parameter [21:0] DET_CYCLES = `RTI_DET_INTERVAL_US * `RTI_CLK_MHZ,
    parameter [21:0] ACC_CYCLES = `RTI_ACC_WAIT_MS * 1000 * `RTI_CLK_MHZ
) (
    input wire clk,
    input wire sys_rst,
    input wire ce,
    input wire tick_1hz,
    input wire scl_i,
    input wire sda_i,
    input wire vdd_ok_i,
    input wire vbat_ok_i,
    input wire [7:0] rd_data,
    output reg sda_o,
    output reg sda_oe,
    output reg [7:0] wr_data,
    output reg wr_stb,
    output reg rd_stb,
    output reg busy,
    output reg tout_evt,
    output reg por_rst,
    output reg on_backup,
    output reg acc_ready
);

// ****************************************************************
// declarations
// ****************************************************************
localparam [21:0] DET_LAST = DET_CYCLES - 22'h1; // last count of a detector interval
localparam [21:0] ACC_LAST = ACC_CYCLES - 22'h1; // last count of the access wait
localparam [4:0] POR_LAST = `RTI_POR_CYCLES - 5'h1; // last count of power-on reset

wire [3:0] pins_s; // synchronised pins
wire scl_s = pins_s[0];
wire sda_s = pins_s[1];
wire vdd_s = pins_s[2];
wire vbat_s = pins_s[3];

reg scl_q_r; // previous scl, for edges
reg sda_q_r; // previous sda, for start/stop
reg [2:0] st_r; // port state
reg [3:0] bit_cnt_r; // bits of the current byte
reg [7:0] shift_r; // incoming or outgoing byte
reg rw_r; // read transfer flag
reg armed_r; // watchdog running
reg [1:0] tick_cnt_r; // 1 Hz ticks since address
reg any_q_r; // previous either-supply level
reg [4:0] por_cnt_r; // power-on reset length
reg [21:0] det_cnt_r; // backup detector interval
reg [21:0] acc_cnt_r; // access wait counter

wire scl_rise = scl_s & ~scl_q_r;
wire scl_fall = ~scl_s & scl_q_r;
wire start_c = scl_s & scl_q_r & sda_q_r & ~sda_s; // sda falls, scl high
wire stop_c = scl_s & scl_q_r & ~sda_q_r & sda_s; // sda rises, scl high
wire tout_c = armed_r & tick_1hz & (tick_cnt_r == `RTI_TOUT_TICKS - 2'h1); // second tick
wire pwr_any = vdd_s | vbat_s;

// ****************************************************************
// pin synchroniser
// ****************************************************************
rti_sync #(
    .W(4)
) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .d({vbat_ok_i, vdd_ok_i, sda_i, scl_i}),
    .q(pins_s)
);

// ****************************************************************
// serial slave port and watchdog
// ****************************************************************
// byte engine; the host keeps each transfer under one second RULE2
always @(posedge clk)
begin
    if (sys_rst)
    begin
        scl_q_r <= 1'b1;
        sda_q_r <= 1'b1;
        st_r <= `RTI_ST_IDLE;
        bit_cnt_r <= 4'h0;
        shift_r <= 8'h00;
        rw_r <= 1'b0;
        armed_r <= 1'b0;
        tick_cnt_r <= 2'h0;
        sda_o <= 1'b0;
        sda_oe <= 1'b0;
        wr_data <= 8'h00;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        busy <= 1'b0;
        tout_evt <= 1'b0;
    end
    else if (ce)
    begin
        scl_q_r <= scl_s;
        sda_q_r <= sda_s;
        // count watchdog ticks while armed, even in a start or stop cycle
        if (armed_r & tick_1hz)
        begin
            tick_cnt_r <= tick_cnt_r + 2'h1; // RULE1
        end
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        tout_evt <= 1'b0;
        if (por_rst | tout_c)
        begin
            // interface reset: drop the transfer, let sda float
            st_r <= `RTI_ST_IDLE; // RULE1
            sda_oe <= 1'b0; // RULE1
            armed_r <= 1'b0;
            busy <= 1'b0;
            tout_evt <= tout_c;
        end
        else if (start_c)
        begin
            // new or repeated start; any partial byte is dropped unwritten
            st_r <= `RTI_ST_ADDR; // RULE4
            bit_cnt_r <= 4'h0;
            sda_oe <= 1'b0;
            busy <= 1'b1;
        end
        else if (stop_c)
        begin
            // stop ends the transfer and the watchdog
            st_r <= `RTI_ST_IDLE; // RULE4
            armed_r <= 1'b0; // RULE9
            sda_oe <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            case (st_r)
                `RTI_ST_ADDR, `RTI_ST_WDAT:
                begin
                    if (scl_rise && bit_cnt_r != `RTI_BYTE_BITS)
                    begin
                        // data bit taken on the rising edge
                        shift_r <= {shift_r[6:0], sda_s}; // RULE3
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_r == `RTI_BYTE_BITS)
                    begin
                        if (st_r == `RTI_ST_WDAT)
                        begin
                            // whole byte: commit while driving ack
                            wr_data <= shift_r; // RULE3
                            wr_stb <= 1'b1; // RULE3
                            sda_oe <= 1'b1; // RULE3
                            st_r <= `RTI_ST_WACK;
                        end
                        else if (shift_r[7:1] == `RTI_SLAVE_ADDR)
                        begin
                            // our address: ack and restart the watchdog
                            rw_r <= shift_r[0];
                            sda_oe <= 1'b1;
                            armed_r <= 1'b1; // RULE9
                            tick_cnt_r <= 2'h0; // RULE9
                            st_r <= `RTI_ST_AACK;
                        end
                        else
                        begin
                            // another slave: stay off the bus
                            st_r <= `RTI_ST_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
                `RTI_ST_AACK:
                begin
                    // end of ack slot; reads load the first data bit here
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        sda_oe <= 1'b0;
                        st_r <= `RTI_ST_WDAT;
                        if (rw_r)
                        begin
                            shift_r <= rd_data;
                            sda_oe <= ~rd_data[7];
                            rd_stb <= 1'b1;
                            bit_cnt_r <= 4'h1;
                            st_r <= `RTI_ST_RDAT;
                        end
                    end
                end
                `RTI_ST_WACK:
                begin
                    // release ack, next byte
                    if (scl_fall)
                    begin
                        sda_oe <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        st_r <= `RTI_ST_WDAT;
                    end
                end
                `RTI_ST_RDAT:
                begin
                    // shift out msb first on falling edges
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == `RTI_BYTE_BITS)
                        begin
                            sda_oe <= 1'b0;
                            st_r <= `RTI_ST_RACK;
                        end
                        else
                        begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe <= ~shift_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                `RTI_ST_RACK:
                begin
                    // host ack: another byte; nack: wait for stop
                    if (scl_rise)
                    begin
                        st_r <= sda_s ? `RTI_ST_IDLE : `RTI_ST_AACK;
                    end
                end
                default:
                begin
                    // idle: only start leaves
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end
end

// ****************************************************************
// power-on reset, backup switching and access wait
// ****************************************************************
// supply sequencing; the host honours acc_ready RULE5 RULE6
always @(posedge clk)
begin
    if (sys_rst)
    begin
        any_q_r <= 1'b0;
        por_cnt_r <= 5'h00;
        por_rst <= 1'b0;
        det_cnt_r <= 22'h000000;
        on_backup <= 1'b0;
        acc_cnt_r <= 22'h000000;
        acc_ready <= 1'b0;
    end
    else if (ce)
    begin
        any_q_r <= pwr_any;
        // first supply of either kind starts the reset pulse
        if (pwr_any & ~any_q_r)
        begin
            por_rst <= 1'b1; // RULE8
            por_cnt_r <= 5'h00;
        end
        else if (por_rst)
        begin
            if (por_cnt_r == POR_LAST)
            begin
                por_rst <= 1'b0;
            end
            else
            begin
                por_cnt_r <= por_cnt_r + 5'h01;
            end
        end
        // backup: look at main supply only at interval ends
        if (on_backup)
        begin
            if (det_cnt_r == DET_LAST)
            begin
                det_cnt_r <= 22'h000000; // RULE7
                on_backup <= ~vdd_s; // RULE7
            end
            else
            begin
                det_cnt_r <= det_cnt_r + 22'h000001; // RULE7
            end
        end
        else if (~vdd_s & vbat_s)
        begin
            on_backup <= 1'b1;
            det_cnt_r <= 22'h000000;
        end
        // access wait restarts whenever main supply is absent
        if (~vdd_s | on_backup)
        begin
            acc_cnt_r <= 22'h000000; // RULE6
            acc_ready <= 1'b0;
        end
        else if (acc_cnt_r == ACC_LAST)
        begin
            acc_ready <= 1'b1; // RULE5
        end
        else
        begin
            acc_cnt_r <= acc_cnt_r + 22'h000001;
        end
    end
end

endmodule

// ===== tb/rti_top_sva.sv
// Purpose: port-level checks for rti_top
// Assumes: one clock domain, ce may pause it briefly
// Notes: bound to rti_top at the foot of this file
`timescale 1ns/1ps
module rti_top_sva (
    input wire clk,
    input wire sys_rst,
    input wire tick_1hz,
    input wire sda_oe,
    input wire wr_stb,
    input wire tout_evt,
    input wire busy,
    input wire por_rst,
    input wire on_backup,
    input wire acc_ready
);
    // ****************
    // checks
    // ****************
    reg [5:0] por_cnt_r; // cycles of power-on reset so far
    // count how long power-on reset has stood
    always @(posedge clk)
    begin
        por_cnt_r <= (sys_rst || !por_rst) ? 6'h00 : por_cnt_r + 6'h01;
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wr_ack_a: assert property (wr_stb |-> $rose(sda_oe))
        else $error("byte commit without ack");
    wr_once_a: assert property (wr_stb |=> !wr_stb)
        else $error("commit strobe too long");
    tout_rel_a: assert property (tout_evt |=> !sda_oe && !busy)
        else $error("port not released by watchdog");
    tout_tick_a: assert property (tout_evt |-> $past(tick_1hz) || $past(tick_1hz, 2))
        else $error("watchdog fired without tick");
    tout_once_a: assert property (tout_evt |=> !tout_evt)
        else $error("watchdog event too long");
    por_len_a: assert property ($fell(por_rst) |-> por_cnt_r == 6'h10)
        else $error("power-on reset length wrong");
    por_quiet_a: assert property (por_rst |-> !sda_oe && !wr_stb)
        else $error("port active in power-on reset");
    acc_bak_a: assert property ($rose(on_backup) |-> ##[0:1] !acc_ready)
        else $error("ready kept on backup");
    acc_wait_a: assert property ($rose(acc_ready) |-> !$past(on_backup, 8) && !por_rst)
        else $error("ready too early");
    tout_c: cover property ($rose(tout_evt));
    wr_c: cover property (wr_stb);
    ret_c: cover property ($fell(on_backup));
endmodule

bind rti_top rti_top_sva chk (.clk(clk), .sys_rst(sys_rst), .tick_1hz(tick_1hz), .sda_oe(sda_oe),
    .wr_stb(wr_stb), .tout_evt(tout_evt), .busy(busy), .por_rst(por_rst), .on_backup(on_backup),
    .acc_ready(acc_ready));

// ===== tb/rti_host.sv
// Purpose: bus master model for the two-wire port
// Assumes: pull-up on the data line, 160 ns link period
// Notes: clock line stands high between frames
`timescale 1ns/1ps
module rti_host (
    input wire clk,
    input wire sda_oe,
    output reg scl,
    output reg sda_h,
    output wire sda
);
    // ****************
    // wire and tasks
    // ****************
    assign sda = sda_h & ~sda_oe; // pulled up unless someone pulls low
    initial
    begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // wait whole clock cycles
    task w(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // start or repeated start; the bench checks the access wait first
    task start;
    begin
        sda_h <= 1'b1;
        w(4);
        scl <= 1'b1;
        w(4);
        sda_h <= 1'b0;
        w(8);
        scl <= 1'b0;
        w(4);
    end
    endtask
    // send k bits msb first, sampling the wire at mid-high
    task bits(input [7:0] v, input integer k, output [7:0] rx);
        integer i;
    begin
        for (i = 7; i > 7 - k; i = i - 1)
        begin
            sda_h <= v[i];
            w(4);
            scl <= 1'b1;
            w(4);
            #1;
            rx = {rx[6:0], sda};
            w(4);
            scl <= 1'b0;
            w(4);
        end
    end
    endtask
    // stop ends a frame; t_dog holds one frame open across two 1 Hz ticks so the watchdog fires
    task stop;
    begin
        sda_h <= 1'b0;
        w(4);
        scl <= 1'b1;
        w(4);
        sda_h <= 1'b1;
        w(8);
    end
    endtask
endmodule

// ===== tb/rti_top_tb.sv
// Purpose: self-checking bench for rti_top
// Assumes: 100 MHz clock, shortened supply counts
// Notes: rti_host drives the bus, the bench drives supplies and ticks
`timescale 1ns/1ps
module rti_top_tb;
    // ****************
    // bench
    // ****************
    localparam DET = 40; // shortened detector interval
    localparam ACC = 30; // shortened access wait
    reg clk, sys_rst, ce, tick_1hz, vdd_ok_i, vbat_ok_i;
    reg [7:0] rd_data, r;
    wire scl, sda, sda_h, sda_o, sda_oe, wr_stb, rd_stb, busy, tout_evt, por_rst, on_backup, acc_ready;
    wire [7:0] wr_data;
    integer fail_count, total_checks, wcnt, tcnt, rcnt, n, c;
    wire [3:0] mon = {acc_ready, ~on_backup, ~por_rst, por_rst}; // levels to wait on
    rti_top #(.DET_CYCLES(DET), .ACC_CYCLES(ACC)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tick_1hz(tick_1hz), .scl_i(scl), .sda_i(sda), .vdd_ok_i(vdd_ok_i), .vbat_ok_i(vbat_ok_i),
        .rd_data(rd_data), .sda_o(sda_o), .sda_oe(sda_oe), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .busy(busy), .tout_evt(tout_evt), .por_rst(por_rst),
        .on_backup(on_backup), .acc_ready(acc_ready));
    rti_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda_h(sda_h),
        .sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count commits and watchdog events
    always @(posedge clk)
    begin
        if (wr_stb === 1'b1)
            wcnt <= wcnt + 1;
        if (tout_evt === 1'b1)
            tcnt <= tcnt + 1;
        if (rd_stb === 1'b1)
            rcnt <= rcnt + 1;
    end
    task chk(input [7:0] got, input [7:0] exp, input string nm);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // bounded wait on a watched level, n counts cycles
    task wt(input integer sel, input integer lim);
    begin
        n = 0;
        while (mon[sel] !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n = n + 1;
            if (n > lim)
            begin
                fail_count = fail_count + 1;
                report_and_stop;
            end
        end
    end
    endtask
    task pulse;
    begin
        @(posedge clk);
        tick_1hz <= 1'b1;
        @(posedge clk);
        tick_1hz <= 1'b0;
        repeat (6) @(posedge clk);
    end
    endtask
    task addr(input [6:0] a, input rw, input lv);
    begin
        wt(3, 200);
        host.start;
        host.bits({a, rw}, 8, r);
        host.bits(8'hFF, 1, r);
        chk(r[0], lv, "address ack");
    end
    endtask
    task t_power;
    begin
        @(posedge clk);
        vbat_ok_i <= 1'b1;
        wt(0, 10);
        wt(1, 40);
        chk(n, 16, "por length");
        chk(on_backup, 1'b1, "backup mode");
        @(posedge clk);
        vdd_ok_i <= 1'b1;
        repeat (8) @(posedge clk);
        chk(on_backup, 1'b1, "backup held to interval end");
        wt(2, DET);
        chk(acc_ready, 1'b0, "ready early");
        wt(3, ACC + 6);
        chk(n >= ACC, 1'b1, "access wait");
        $display("test power done");
    end
    endtask
    task t_write;
    begin
        c = wcnt;
        addr(7'h32, 1'b0, 1'b0);
        host.bits(8'hA5, 8, r);
        host.bits(8'hFF, 1, r);
        chk(r[0], 1'b0, "data ack");
        chk(wr_data, 8'hA5, "commit data");
        host.stop;
        chk(busy, 1'b0, "busy after stop");
        addr(7'h32, 1'b0, 1'b0);
        host.bits(8'h3C, 5, r);
        host.stop;
        chk(wcnt - c, 1, "partial discarded");
        chk(wr_data, 8'hA5, "register kept");
        addr(7'h33, 1'b0, 1'b1);
        host.stop;
        $display("test write done");
    end
    endtask
    task t_dog;
    begin
        c = tcnt;
        addr(7'h32, 1'b0, 1'b0);
        pulse;
        addr(7'h32, 1'b0, 1'b0);
        pulse;
        chk(tcnt - c, 0, "restart on address");
        ce <= 1'b0;
        pulse;
        ce <= 1'b1;
        chk(tcnt - c, 0, "tick ignored while frozen");
        pulse;
        chk(tcnt - c, 1, "fired on second tick");
        chk(sda_oe, 1'b0, "line released");
        chk(busy, 1'b0, "port reset");
        host.stop;
        addr(7'h32, 1'b0, 1'b0);
        pulse;
        host.stop;
        pulse;
        pulse;
        chk(tcnt - c, 1, "stop disarms");
        @(posedge clk);
        rd_data <= 8'h96;
        c = rcnt;
        addr(7'h32, 1'b1, 1'b0);
        host.bits(8'hFF, 8, r);
        chk(r, 8'h96, "read byte");
        chk(rcnt - c, 1, "read byte loaded once");
        chk(sda_o, 1'b0, "data pin only pulls low");
        host.bits(8'hFF, 1, r);
        host.stop;
        $display("test watchdog and read done");
    end
    endtask
    initial
    begin
        fail_count = 0;
        total_checks = 0;
        wcnt = 0;
        tcnt = 0;
        rcnt = 0;
        ce = 1'b1;
        sys_rst = 1'b1;
        tick_1hz = 1'b0;
        vdd_ok_i = 1'b0;
        vbat_ok_i = 1'b0;
        rd_data = 8'h00;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_power;
        t_write;
        t_dog;
        report_and_stop;
    end
    // cut a hang short
    initial
    begin
        #1000000;
        fail_count = fail_count + 1;
        report_and_stop;
    end
endmodule
